// ===== rtl/rfis_pkg.sv
/*
  Constants for the converter start-up sequencer: timing figures, derived
  cycle counts, set identifiers and sequencer states.
  Assumes a 250 MHz system clock.
*/
package rfis_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned PWRUP_DELAY_MS = 1;
  localparam int unsigned RESET_PULSE_US = 1;
  localparam int unsigned RESET_TO_SEL_NS = 100;
  localparam int unsigned ESTIMATE_WAIT_MS = 50;
  // Least times round up to whole cycles
  localparam int unsigned PWRUP_CYCLES = (PWRUP_DELAY_MS * 1000000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int unsigned RESET_CYCLES = (RESET_PULSE_US * 1000000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int unsigned SEL_GAP_CYCLES = (RESET_TO_SEL_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam longint unsigned ESTIMATE_CYCLES_L =
    (64'(ESTIMATE_WAIT_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS);
  localparam int unsigned ESTIMATE_CYCLES = int'(ESTIMATE_CYCLES_L);
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SET_W = 3;
  // Register sets in write order
  localparam logic [2:0] SET_TRIM = 3'h0;
  localparam logic [2:0] SET_IL_A = 3'h1;
  localparam logic [2:0] SET_IL_B = 3'h2;
  localparam logic [2:0] SET_NL_A = 3'h3;
  localparam logic [2:0] SET_NL_B = 3'h4;
  localparam logic [2:0] SET_DDC = 3'h5;

  typedef enum logic [3:0] {
    RFIS_IDLE = 4'h0,
    RFIS_PWRUP = 4'h1,
    RFIS_RESET = 4'h2,
    RFIS_GAP = 4'h3,
    RFIS_WRITE = 4'h4,
    RFIS_ESTIMATE = 4'h5,
    RFIS_DONE = 4'h6
  } rfis_state_t;
endpackage : rfis_pkg

// ===== rtl/rfis_cnt_if.sv
/*
  Carrier between the sequencer and its delay counter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface rfis_cnt_if #(parameter int unsigned W = 24);
  logic load;
  logic [W-1:0] count;
  logic expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : rfis_cnt_if
`default_nettype wire

// ===== rtl/rfis_timer.sv
/*
  Down counter for the sequencer's waits; expired is registered.
  Assumes load is a one-cycle pulse on the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rfis_timer #(parameter int unsigned W = 24) (
  input wire logic clk,
  input wire logic rst_n,
  rfis_cnt_if.tmr cnt
);
  logic [W-1:0] remain_reg;
  logic expired_reg;

  // Load then count down to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain_reg <= '0;
      expired_reg <= 1'b0;
    end else if (cnt.load) begin
      remain_reg <= cnt.count;
      expired_reg <= 1'b0;
    end else if (remain_reg != '0) begin
      remain_reg <= remain_reg - 1'b1;
      expired_reg <= (remain_reg == W'(1));
    end else begin
      expired_reg <= 1'b0;
    end
  end
  assign cnt.expired = expired_reg;
endmodule : rfis_timer
`default_nettype wire

// ===== rtl/rfis_seq.sv
/*
  Host-side start-up sequencer for a dual-channel RF sampling converter.
  Drives reset and the reference enable, then asks a serial writer to
  stream each register set in order, waiting out the error estimate.
  Assumes an external serial writer that owns the select pin and
  answers each set request with a one-cycle done pulse.
*/
// Function
// (R1) Present the reference signal before pulsing reset.
// (R2) Reset is a single low-high-low pulse.
// (R3) Trim set is written first after every reset.
// (R4) Channel A interleave set follows the trim set.
// (R5) Channel B interleave set follows channel A interleave.
// (R6) Wait 50 ms after interleave sets, no writes meanwhile.
// (R7) Channel A nonlinearity set follows the wait.
// (R8) Channel B nonlinearity set follows channel A nonlinearity.
// (R9) Down-converter and link set is written last.
// (R10) Wait at least 1 ms after power-up before reset rises.
// (R11) Hold reset high at least 1 us.
// (R12) Wait at least 100 ns after reset falls before any write.
// (R13) Advance only after each set's writes have all completed.
`timescale 1ns/1ps
`default_nettype none
module rfis_seq
  import rfis_pkg::*;
#(
  parameter int unsigned PWRUP_CNT = PWRUP_CYCLES,
  parameter int unsigned RESET_CNT = RESET_CYCLES,
  parameter int unsigned GAP_CNT = SEL_GAP_CYCLES,
  parameter int unsigned ESTIMATE_CNT = ESTIMATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic set_done,
  output logic sysref_en,
  output logic adc_reset,
  output logic set_req,
  output logic [SET_W-1:0] set_id,
  output logic busy,
  output logic seq_done
);
  initial begin
    if (PWRUP_CNT < 1 || RESET_CNT < 1 || GAP_CNT < 1 || ESTIMATE_CNT < 1 ||
        PWRUP_CNT >= (1 << CNT_W) || ESTIMATE_CNT >= (1 << CNT_W) ||
        RESET_CNT >= (1 << CNT_W) || GAP_CNT >= (1 << CNT_W))
      $error("rfis_seq: delay counts out of range");
  end

  rfis_state_t state_reg;
  logic sysref_en_reg, adc_reset_reg, set_req_reg, busy_reg, seq_done_reg;
  logic [SET_W-1:0] set_id_reg;
  logic load_reg;
  logic [CNT_W-1:0] count_reg;

  rfis_cnt_if #(.W(CNT_W)) cnt ();
  assign cnt.load = load_reg;
  assign cnt.count = count_reg;

  rfis_timer #(.W(CNT_W)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .cnt(cnt)
  );

  // Sequence of waits and set requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RFIS_IDLE;
      load_reg <= 1'b0;
      count_reg <= '0;
      set_id_reg <= SET_TRIM;
      set_req_reg <= 1'b0;
    end else begin
      load_reg <= 1'b0;
      set_req_reg <= 1'b0;
      unique case (state_reg)
        RFIS_IDLE: begin
          if (start) begin
            state_reg <= RFIS_PWRUP;
            load_reg <= 1'b1;
            count_reg <= CNT_W'(PWRUP_CNT); // see (R10)
          end
        end
        RFIS_PWRUP: begin
          if (cnt.expired) begin
            state_reg <= RFIS_RESET;
            load_reg <= 1'b1;
            count_reg <= CNT_W'(RESET_CNT); // see (R11)
          end
        end
        RFIS_RESET: begin
          if (cnt.expired) begin
            state_reg <= RFIS_GAP;
            load_reg <= 1'b1;
            count_reg <= CNT_W'(GAP_CNT); // see (R12)
          end
        end
        RFIS_GAP: begin
          if (cnt.expired) begin
            state_reg <= RFIS_WRITE;
            set_id_reg <= SET_TRIM; // see (R3)
            set_req_reg <= 1'b1;
          end
        end
        RFIS_WRITE: begin
          if (set_done) begin // see (R13)
            if (set_id_reg == SET_IL_B) begin
              state_reg <= RFIS_ESTIMATE;
              load_reg <= 1'b1;
              count_reg <= CNT_W'(ESTIMATE_CNT); // see (R6)
            end else if (set_id_reg == SET_DDC) begin
              state_reg <= RFIS_DONE; // see (R9)
            end else begin
              set_id_reg <= set_id_reg + 1'b1; // see (R4) (R5) (R8)
              set_req_reg <= 1'b1;
            end
          end
        end
        RFIS_ESTIMATE: begin
          if (cnt.expired) begin
            state_reg <= RFIS_WRITE;
            set_id_reg <= SET_NL_A; // see (R7)
            set_req_reg <= 1'b1;
          end
        end
        RFIS_DONE: begin
          if (start) begin
            state_reg <= RFIS_PWRUP;
            load_reg <= 1'b1;
            count_reg <= CNT_W'(PWRUP_CNT);
          end
        end
        default: state_reg <= RFIS_IDLE;
      endcase
    end
  end

  // Pin levels registered from the next state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_en_reg <= 1'b0;
      adc_reset_reg <= 1'b0;
      busy_reg <= 1'b0;
      seq_done_reg <= 1'b0;
    end else begin
      if (state_reg == RFIS_PWRUP && cnt.expired) begin
        adc_reset_reg <= 1'b1; // see (R2)
      end else if (state_reg == RFIS_RESET && cnt.expired) begin
        adc_reset_reg <= 1'b0; // see (R2)
      end
      if ((state_reg == RFIS_IDLE || state_reg == RFIS_DONE) && start) begin
        sysref_en_reg <= 1'b1; // see (R1)
        busy_reg <= 1'b1;
        seq_done_reg <= 1'b0;
      end else if (state_reg == RFIS_WRITE && set_done && set_id_reg == SET_DDC) begin
        busy_reg <= 1'b0;
        seq_done_reg <= 1'b1;
      end
    end
  end

  assign sysref_en = sysref_en_reg;
  assign adc_reset = adc_reset_reg;
  assign set_req = set_req_reg;
  assign set_id = set_id_reg;
  assign busy = busy_reg;
  assign seq_done = seq_done_reg;

  // Reset high length: count cycles of the pulse
  logic [CNT_W-1:0] hi_len_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hi_len_reg <= '0;
    else if (adc_reset_reg) hi_len_reg <= hi_len_reg + 1'b1;
    else hi_len_reg <= '0;
  end

  chk_reset_width: assert property (@(posedge clk) disable iff (!rst_n) // see (R11)
    $fell(adc_reset_reg) |-> $past(hi_len_reg) >= CNT_W'(RESET_CNT))
    else $error("reset pulse too short");
  chk_sysref_first: assert property (@(posedge clk) disable iff (!rst_n) // see (R1)
    $rose(adc_reset_reg) |-> sysref_en_reg)
    else $error("reset raised before reference enabled");
  chk_trim_first: assert property (@(posedge clk) disable iff (!rst_n) // see (R3)
    ($past(state_reg) == RFIS_GAP && state_reg == RFIS_WRITE) |-> set_id_reg == SET_TRIM)
    else $error("first set not trim");
  chk_no_req_wait: assert property (@(posedge clk) disable iff (!rst_n) // see (R6)
    state_reg == RFIS_ESTIMATE |-> !set_req_reg)
    else $error("write during estimate wait");
  chk_estimate_entry: assert property (@(posedge clk) disable iff (!rst_n) // see (R6)
    ($past(state_reg) == RFIS_WRITE && state_reg == RFIS_ESTIMATE)
      |-> $past(set_id_reg) == SET_IL_B)
    else $error("estimate not after channel B interleave");
  chk_set_order: assert property (@(posedge clk) disable iff (!rst_n) // see (R13)
    (set_req_reg && $past(state_reg) == RFIS_WRITE) |-> $past(set_done)
      && set_id_reg == $past(set_id_reg) + 1'b1)
    else $error("set order broken");
  chk_nl_after_wait: assert property (@(posedge clk) disable iff (!rst_n) // see (R7)
    ($past(state_reg) == RFIS_ESTIMATE && state_reg == RFIS_WRITE) |-> set_id_reg == SET_NL_A)
    else $error("nonlinearity A not after wait");
  chk_ddc_last: assert property (@(posedge clk) disable iff (!rst_n) // see (R9)
    $rose(seq_done_reg) |-> $past(set_id_reg) == SET_DDC)
    else $error("done before down-converter set");
  chk_gap_write: assert property (@(posedge clk) disable iff (!rst_n) // see (R12)
    $fell(adc_reset_reg) |-> !set_req_reg [*2])
    else $error("write too soon after reset");
endmodule : rfis_seq
`default_nettype wire

// ===== test/rfis_dev_model.sv
/*
  Converter model: answers set requests after a chosen delay and counts
  faults on its reset, reference and request pins.
  Assumes one clock and a one-cycle request pulse from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module rfis_dev_model #(
  parameter int unsigned RST_MIN = 5,
  parameter int unsigned GAP_MIN = 3,
  parameter int unsigned EST_MIN = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sysref_en,
  input wire logic adc_reset,
  input wire logic set_req,
  input wire logic [2:0] set_id,
  input wire logic [3:0] dly,
  output logic set_done,
  output logic [7:0] errs
);
  logic rst_q;
  logic busy_q;
  logic [3:0] wait_q;
  logic [2:0] exp_q;
  int hi;
  int lo;
  int est;
  // Pin checks and delayed answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rst_q, busy_q, set_done, wait_q, exp_q, errs} <= '0;
      hi <= 0;
      lo <= 0;
      est <= 0;
    end else begin
      rst_q <= adc_reset;
      hi <= adc_reset ? hi + 1 : 0;
      lo <= adc_reset ? 0 : lo + 1;
      est <= est + 1;
      set_done <= 1'b0;
      if (adc_reset && !rst_q && (!sysref_en || busy_q)) errs <= errs + 8'h01;
      if (adc_reset && !rst_q) exp_q <= 3'h0;
      if (!adc_reset && rst_q && hi < RST_MIN) errs <= errs + 8'h01;
      if (set_req) begin
        if (set_id !== exp_q || busy_q || adc_reset)
          errs <= errs + 8'h01;
        if (set_id == 3'h0 && lo < GAP_MIN) errs <= errs + 8'h01;
        if (set_id == 3'h3 && est < EST_MIN) errs <= errs + 8'h01;
        exp_q <= exp_q + 3'h1;
        busy_q <= 1'b1;
        wait_q <= dly;
      end else if (busy_q && wait_q == 4'h0) begin
        set_done <= 1'b1;
        busy_q <= 1'b0;
        if (set_id == 3'h2) est <= 0;
      end else if (busy_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : rfis_dev_model
`default_nettype wire

// ===== test/testbench.sv
/*
  Self-checking bench for the start-up sequencer with a converter model.
  Assumes short delay counts in place of the real ones.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s expected %0d seen %0d", nm, e, g); end end
module testbench;
  import rfis_pkg::*;
  localparam int PW = 20, RC = 5, GC = 3, EC = 30;
  logic clk = 0, rst_n = 0, start = 0, set_done, sysref_en, adc_reset, set_req, busy, seq_done;
  logic [SET_W-1:0] set_id;
  logic [3:0] dly = 0;
  logic [7:0] errs;
  int n_errors = 0, cmp_count = 0, cyc = 0, t_s, t_rise, t_fall;
  int t_req[6], t_dn[6];
  logic rq = 0;
  logic [2:0] ids[$];
  rfis_seq #(.PWRUP_CNT(PW), .RESET_CNT(RC), .GAP_CNT(GC), .ESTIMATE_CNT(EC)) DUT (.clk(clk),
    .rst_n(rst_n), .start(start), .set_done(set_done), .sysref_en(sysref_en),
    .adc_reset(adc_reset), .set_req(set_req), .set_id(set_id), .busy(busy), .seq_done(seq_done));
  rfis_dev_model #(.RST_MIN(RC), .GAP_MIN(GC), .EST_MIN(EC)) model (.clk(clk), .rst_n(rst_n),
    .sysref_en(sysref_en), .adc_reset(adc_reset), .set_req(set_req), .set_id(set_id),
    .dly(dly), .set_done(set_done), .errs(errs));
  // Clock
  always #2 clk = ~clk;
  // Event times at each edge
  always @(posedge clk) begin
    cyc++;
    if (start && !busy) t_s = cyc;
    if (adc_reset && !rq) t_rise = cyc;
    if (!adc_reset && rq) t_fall = cyc;
    rq = adc_reset;
    if (set_req) begin
      t_req[set_id] = cyc;
      ids.push_back(set_id);
    end
    if (set_done) t_dn[set_id] = cyc;
  end
  task automatic chk_idle;
    `CHK("outputs", 8'h00, {sysref_en, adc_reset, set_req, busy, seq_done, set_id})
  endtask : chk_idle
  // Full sequence, optional start while busy
  task automatic t_run(input logic [3:0] d, input bit again);
    ids = {};
    dly = d;
    @(negedge clk) start = 1;
    @(negedge clk) start = 0;
    if (again) begin
      repeat (10) @(negedge clk);
      start = 1;
      @(negedge clk) start = 0;
    end
    for (int i = 0; i < 500 && !seq_done; i++) @(negedge clk);
    // Pin times are seen one edge after launch; start at its own sampling edge
    `CHK("model faults", 8'h00, errs)
    `CHK("power-up delay", PW + 3, t_rise - t_s)
    `CHK("reset width", RC + 2, t_fall - t_rise)
    `CHK("select gap", GC + 2, t_req[0] - t_fall)
    `CHK("set count", 6, ids.size())
    for (int i = 0; i < 6 && i < ids.size(); i++)
      `CHK("set order", i, ids[i])
    for (int i = 1; i < 6; i++)
      if (i != 3) `CHK("advance", 1, t_req[i] - t_dn[i - 1])
    `CHK("estimate wait", EC + 3, t_req[3] - t_dn[2])
    `CHK("finished", 3'h3, {busy, seq_done, sysref_en})
    $display("test run delay %0d done", d);
  endtask : t_run
  // Reset in mid-sequence clears every output
  task automatic t_midreset;
    @(negedge clk) start = 1;
    @(negedge clk) start = 0;
    for (int i = 0; i < 200 && !set_req; i++) @(negedge clk);
    `CHK("write reached", 1'b1, set_req)
    rst_n = 0;
    @(negedge clk) chk_idle();
    rst_n = 1;
    $display("test mid reset done");
  endtask : t_midreset
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    #40000;
    n_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    chk_idle();
    rst_n = 1;
    t_run(4'h0, 0);
    t_run(4'h7, 1);
    t_midreset();
    t_run(4'h2, 0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
